// *** inc/hsc_params.svh ***
// register map, field positions, reset values and timing counts
`ifndef HSC_PARAMS_SVH
`define HSC_PARAMS_SVH

`define HSC_ADR_OSC_CTRL 8'h00
`define HSC_ADR_MAIN_OSC 8'h04
`define HSC_ADR_MAIN_MODE 8'h08
`define HSC_ADR_PROC_CLK 8'h0c
`define HSC_ADR_STAB_STAT 8'h10
`define HSC_ADR_STAB_SEL 8'h14

`define HSC_BIT_GAIN 0
`define HSC_BIT_PIN_FUNC 6
`define HSC_BIT_EXT_IN 7
`define HSC_BIT_HS_STOP 7
`define HSC_BIT_MAIN_SEL 0
`define HSC_BIT_MAIN_FLAG 1
`define HSC_BIT_SRC_SEL 2
`define HSC_BIT_CPU_SRC 4
`define HSC_BIT_SUB_FLAG 5

`define HSC_RST_HS_STOP 1'b1
`define HSC_RST_DIV 3'h1
`define HSC_RST_STAB_SEL 3'h5

`define HSC_CLK_PERIOD_NS 50
`define HSC_PAUSE_MIN_NS 4060
`define HSC_PAUSE_CYC \
  ((`HSC_PAUSE_MIN_NS + `HSC_CLK_PERIOD_NS - 1) / `HSC_CLK_PERIOD_NS)
`define HSC_PAUSE_EXT_EDGES 160
`define HSC_STAB_BASE_LOG2 8

`endif

// *** inc/hsc_pkg.sv ***
// types shared by the high-speed clock control block
package hsc_pkg;
  typedef enum logic [1:0] {
    HSC_RUN = 2'b00,
    HSC_PAUSE_XTAL = 2'b01,
    HSC_PAUSE_EXT = 2'b10,
    HSC_WAKE = 2'b11
  } hsc_state_t;
  typedef logic [2:0] hsc_div_code_t;
endpackage

// *** inc/hsc_div_if.sv ***
// link between the clock control core and the cpu clock divider
`timescale 1ns/10ps
interface hsc_div_if;
  logic tick;
  hsc_pkg::hsc_div_code_t code;
  logic cpu_tick;
  hsc_pkg::hsc_div_code_t applied;
  modport ctl (output tick, output code, input cpu_tick, input applied);
  modport div (input tick, input code, output cpu_tick, output applied);
endinterface

// *** verilog/hsc_cpu_div.sv ***
// cpu clock divider: power-of-two enable divider with safe code change
`timescale 1ns/10ps
`include "hsc_params.svh"
module hsc_cpu_div #(
  parameter int MAX_CODE = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  hsc_div_if.div div
);
  if (MAX_CODE < 1 || MAX_CODE > 7)
  begin : g_bad
    $error("hsc_cpu_div: MAX_CODE out of range");
  end

  logic [MAX_CODE-1:0] cnt_q;
  logic [MAX_CODE-1:0] mask;
  hsc_pkg::hsc_div_code_t code_q;
  logic wrap;

  assign mask = MAX_CODE'((32'h1 << code_q) - 32'h1);
  assign wrap = div.tick && (cnt_q == mask);
  assign div.cpu_tick = wrap;
  assign div.applied = code_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_q <= '0;
    else if (div.tick)
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
  end

  // the new ratio only takes over at a period end, so no short pulse
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      code_q <= `HSC_RST_DIV;
    else if (wrap && (32'(div.code) <= MAX_CODE))
      code_q <= div.code;
  end

  property p_div_legal;
    @(posedge clk_i) disable iff (!rst_n_i)
    (32'(code_q) <= MAX_CODE);
  endproperty
  a_div_legal: assert property (p_div_legal)
    else $error("divider holds a prohibited code");

  property p_div_one;
    @(posedge clk_i) disable iff (!rst_n_i)
    (div.tick && code_q == 3'h0) |-> div.cpu_tick;
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("divide by one missed a tick");

  property p_div_two;
    @(posedge clk_i) disable iff (!rst_n_i)
    (div.cpu_tick && code_q == 3'h1 && div.code == 3'h1)
      |=> !div.cpu_tick;
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("divide by two ticked twice in a row");
endmodule

// *** verilog/hsc_top.sv ***
// high-speed system clock control: pins, oscillator, source and divider
`timescale 1ns/10ps
`include "hsc_params.svh"
module hsc_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_clk_i,
  input wire logic ext_clk_pin_i,
  input wire logic subsys_tick_i,
  input wire logic stop_insn_i,
  input wire logic wake_i,
  output logic osc_run_o,
  output logic osc_gain_o,
  output logic ext_input_en_o,
  output logic crystal_in_pin_port_o,
  output logic crystal_out_pin_port_o,
  output logic crystal_out_pin_ext_o,
  output logic main_clk_en_o,
  output logic periph_clk_en_o,
  output logic cpu_clk_en_o,
  output logic standby_o
);
  localparam logic [8:0] PAUSE_LAST = 9'(`HSC_PAUSE_CYC - 1);
  localparam logic [8:0] EXT_LAST = 9'(`HSC_PAUSE_EXT_EDGES - 1);

  // ----------------------------------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_q, rst_n;
  logic osc_meta_q, osc_sync_q, ext_meta_q, ext_sync_q;
  logic hs_prev_q, hs_level, hs_edge, hs_tick, hs_on;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // clock pins are sampled, so only inputs below half clk_i are seen
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      hs_prev_q <= 1'b0;
    end
    else
    begin
      osc_meta_q <= osc_clk_i;
      osc_sync_q <= osc_meta_q;
      ext_meta_q <= ext_clk_pin_i;
      ext_sync_q <= ext_meta_q;
      hs_prev_q <= hs_level;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic gain_q, gain_locked_q, ext_sel_q, pin_sel_q, stop_q;
  logic src_sel_q, main_sel_q, main_hs_q, periph_hs_q;
  logic css_q, css_app_q, standby_q;
  hsc_pkg::hsc_div_code_t div_req_q;
  logic [2:0] stab_sel_q;
  logic [15:0] stab_cnt_q;
  hsc_pkg::hsc_state_t state_q, state_d;
  logic [8:0] pause_cnt_q;
  logic xtal_mode, ext_mode, wr, ack_q, gain_set, boundary, main_tick;
  logic [31:0] rd_d;
  hsc_div_if dif ();

  assign xtal_mode = pin_sel_q && !ext_sel_q;
  assign ext_mode = pin_sel_q && ext_sel_q;
  assign hs_level = ext_sel_q ? ext_sync_q : osc_sync_q;
  assign hs_edge = hs_level && !hs_prev_q;
  assign hs_on = (xtal_mode || ext_mode) && !stop_q && !standby_q;
  assign hs_tick = hs_edge && hs_on;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
  assign gain_set = wr && (wb_adr_i == `HSC_ADR_OSC_CTRL) &&
                    !gain_locked_q && !gain_q &&
                    wb_dat_i[`HSC_BIT_GAIN];

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gain_q <= 1'b0;
      gain_locked_q <= 1'b0;
    end
    else if (wr && wb_adr_i == `HSC_ADR_OSC_CTRL && !gain_locked_q &&
             wb_dat_i[`HSC_BIT_GAIN] != gain_q)
    begin
      gain_q <= wb_dat_i[`HSC_BIT_GAIN];
      gain_locked_q <= 1'b1;
    end
  end

  // pin mode bits are trusted to stay put while the clock runs
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_sel_q <= 1'b0;
      pin_sel_q <= 1'b0;
      stop_q <= `HSC_RST_HS_STOP;
      src_sel_q <= 1'b0;
      main_sel_q <= 1'b0;
      css_q <= 1'b0;
      div_req_q <= `HSC_RST_DIV;
      stab_sel_q <= `HSC_RST_STAB_SEL;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        `HSC_ADR_OSC_CTRL:
        begin
          ext_sel_q <= wb_dat_i[`HSC_BIT_EXT_IN];
          pin_sel_q <= wb_dat_i[`HSC_BIT_PIN_FUNC];
        end
        `HSC_ADR_MAIN_OSC: stop_q <= wb_dat_i[`HSC_BIT_HS_STOP];
        `HSC_ADR_MAIN_MODE:
        begin
          src_sel_q <= wb_dat_i[`HSC_BIT_SRC_SEL];
          main_sel_q <= wb_dat_i[`HSC_BIT_MAIN_SEL];
        end
        `HSC_ADR_PROC_CLK:
        begin
          div_req_q <= wb_dat_i[2:0];
          css_q <= wb_dat_i[`HSC_BIT_CPU_SRC];
        end
        `HSC_ADR_STAB_SEL: stab_sel_q <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave: one wait state, unmapped reads give zero
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_d = 32'h0;
    case (wb_adr_i)
      `HSC_ADR_OSC_CTRL:
      begin
        rd_d[`HSC_BIT_GAIN] = gain_q;
        rd_d[`HSC_BIT_PIN_FUNC] = pin_sel_q;
        rd_d[`HSC_BIT_EXT_IN] = ext_sel_q;
      end
      `HSC_ADR_MAIN_OSC: rd_d[`HSC_BIT_HS_STOP] = stop_q;
      `HSC_ADR_MAIN_MODE:
      begin
        rd_d[`HSC_BIT_MAIN_SEL] = main_sel_q;
        rd_d[`HSC_BIT_MAIN_FLAG] = main_hs_q;
        rd_d[`HSC_BIT_SRC_SEL] = src_sel_q;
      end
      `HSC_ADR_PROC_CLK:
      begin
        rd_d[2:0] = div_req_q;
        rd_d[`HSC_BIT_CPU_SRC] = css_q;
        rd_d[`HSC_BIT_SUB_FLAG] = css_app_q;
      end
      `HSC_ADR_STAB_STAT: rd_d[15:0] = stab_cnt_q;
      `HSC_ADR_STAB_SEL: rd_d[2:0] = stab_sel_q;
      default: rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i)
        wb_dat_o <= rd_d;
    end
  end
  assign wb_ack_o = ack_q;

  // ----------------------------------------------------------------
  // stabilization counter and standby
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      stab_cnt_q <= 16'h0;
    else if (!hs_on)
      stab_cnt_q <= 16'h0;
    else if (hs_tick && stab_cnt_q != 16'hffff)
      stab_cnt_q <= stab_cnt_q + 16'h1;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      standby_q <= 1'b0;
    else if (stop_insn_i)
      standby_q <= 1'b1;
    else if (wake_i)
      standby_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // cpu pause sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      hsc_pkg::HSC_RUN:
        if (gain_set)
          state_d = ext_mode ? hsc_pkg::HSC_PAUSE_EXT
                             : hsc_pkg::HSC_PAUSE_XTAL;
        else if (standby_q && wake_i && !stop_insn_i && main_hs_q &&
                 xtal_mode && !css_app_q)
          state_d = hsc_pkg::HSC_WAKE;
      hsc_pkg::HSC_PAUSE_XTAL:
        if (pause_cnt_q == PAUSE_LAST)
          state_d = hsc_pkg::HSC_RUN;
      hsc_pkg::HSC_PAUSE_EXT:
        if (hs_edge && pause_cnt_q == EXT_LAST)
          state_d = hsc_pkg::HSC_RUN;
      hsc_pkg::HSC_WAKE:
        if (stab_cnt_q[`HSC_STAB_BASE_LOG2 + 32'(stab_sel_q)])
          state_d = hsc_pkg::HSC_RUN;
      default: state_d = hsc_pkg::HSC_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= hsc_pkg::HSC_RUN;
      pause_cnt_q <= 9'h0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == hsc_pkg::HSC_RUN)
        pause_cnt_q <= 9'h0;
      else if (state_q == hsc_pkg::HSC_PAUSE_XTAL ||
               (state_q == hsc_pkg::HSC_PAUSE_EXT && hs_edge))
        pause_cnt_q <= pause_cnt_q + 9'h1;
    end
  end

  // ----------------------------------------------------------------
  // source switching and clock enables
  // ----------------------------------------------------------------
  // internal oscillator is clk_i itself, so it ticks every cycle
  assign main_tick = main_hs_q ? hs_tick : 1'b1;
  assign dif.tick = main_tick && !standby_q;
  assign dif.code = div_req_q;
  // switches wait for the end of a cpu period of the running source
  assign boundary = css_app_q ? subsys_tick_i : dif.cpu_tick;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_hs_q <= 1'b0;
      periph_hs_q <= 1'b0;
      css_app_q <= 1'b0;
    end
    else if (boundary)
    begin
      main_hs_q <= src_sel_q && main_sel_q;
      periph_hs_q <= src_sel_q;
      css_app_q <= css_q;
    end
  end

  hsc_cpu_div #(
    .MAX_CODE(4)
  ) u_div (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .div(dif.div)
  );

  assign main_clk_en_o = dif.tick;
  assign periph_clk_en_o = (periph_hs_q ? hs_tick : 1'b1) && !standby_q;
  assign cpu_clk_en_o = (state_q == hsc_pkg::HSC_RUN) && !standby_q &&
                        (css_app_q ? subsys_tick_i : dif.cpu_tick);

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_run_o <= 1'b0;
      ext_input_en_o <= 1'b0;
      crystal_in_pin_port_o <= 1'b1;
      crystal_out_pin_port_o <= 1'b1;
      crystal_out_pin_ext_o <= 1'b0;
    end
    else
    begin
      osc_run_o <= xtal_mode && !stop_q && !standby_q;
      ext_input_en_o <= ext_mode && !stop_q && !standby_q;
      crystal_in_pin_port_o <= !xtal_mode;
      crystal_out_pin_port_o <= !pin_sel_q;
      crystal_out_pin_ext_o <= ext_mode;
    end
  end
  assign osc_gain_o = gain_q;
  assign standby_o = standby_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_gain_lock;
    @(posedge clk_i) disable iff (!rst_n)
    gain_locked_q |=> $stable(gain_q) && gain_locked_q;
  endproperty
  a_gain_lock: assert property (p_gain_lock)
    else $error("gain bit changed after lock");

  property p_gain_high;
    @(posedge clk_i) disable iff (!rst_n)
    osc_gain_o |-> gain_locked_q;
  endproperty
  a_gain_high: assert property (p_gain_high)
    else $error("high gain range without a write");

  property p_pause_xtal;
    @(posedge clk_i) disable iff (!rst_n)
    (state_q == hsc_pkg::HSC_RUN && state_d == hsc_pkg::HSC_PAUSE_XTAL)
      |=> (!cpu_clk_en_o [*8]) ##[74:74] (state_q == hsc_pkg::HSC_PAUSE_XTAL)
      ##1 (state_q == hsc_pkg::HSC_RUN);
  endproperty
  a_pause_xtal: assert property (p_pause_xtal)
    else $error("crystal gain pause length wrong");

  property p_pause_ext;
    @(posedge clk_i) disable iff (!rst_n)
    $fell(state_q == hsc_pkg::HSC_PAUSE_EXT)
      |-> $past(pause_cnt_q) == EXT_LAST && $past(hs_edge);
  endproperty
  a_pause_ext: assert property (p_pause_ext)
    else $error("external gain pause not 160 edges");

  property p_no_cpu_paused;
    @(posedge clk_i) disable iff (!rst_n)
    (state_q != hsc_pkg::HSC_RUN || standby_q) |-> !cpu_clk_en_o;
  endproperty
  a_no_cpu_paused: assert property (p_no_cpu_paused)
    else $error("cpu clocked while halted");

  property p_pins;
    @(posedge clk_i) disable iff (!rst_n)
    pin_sel_q ##1 $stable(ext_sel_q) && $stable(pin_sel_q)
      |-> (crystal_in_pin_port_o == ext_sel_q) &&
          !crystal_out_pin_port_o &&
          (crystal_out_pin_ext_o == ext_sel_q);
  endproperty
  a_pins: assert property (p_pins)
    else $error("clock pin mode does not follow selects");

  property p_osc_off;
    @(posedge clk_i) disable iff (!rst_n)
    (stop_q || standby_q) |=> !osc_run_o && !ext_input_en_o;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator left running when stopped");

  property p_osc_on;
    @(posedge clk_i) disable iff (!rst_n)
    (!stop_q && !standby_q && pin_sel_q)
      |=> (osc_run_o != ext_input_en_o);
  endproperty
  a_osc_on: assert property (p_osc_on)
    else $error("oscillator or input not started");

  property p_internal_runs;
    @(posedge clk_i) disable iff (!rst_n)
    (!main_hs_q && !standby_q) |-> main_clk_en_o;
  endproperty
  a_internal_runs: assert property (p_internal_runs)
    else $error("internal main clock missing");

  property p_periph;
    @(posedge clk_i) disable iff (!rst_n)
    main_hs_q |-> periph_hs_q;
  endproperty
  a_periph: assert property (p_periph)
    else $error("peripheral clock not high-speed");

  property p_flag_switch;
    @(posedge clk_i) disable iff (!rst_n)
    ($changed(main_hs_q) || $changed(css_app_q)) |-> $past(boundary);
  endproperty
  a_flag_switch: assert property (p_flag_switch)
    else $error("source flag moved off a period boundary");
endmodule

// *** tb/hsc_clk_src.sv ***
// crystal resonator and external clock source at the high-speed pins
`timescale 1ns/10ps
module hsc_clk_src #(
  parameter int XTAL_HALF_NS = 100,
  parameter int EXT_HALF_NS = 100
) (
  input wire logic osc_run_i,
  input wire logic ext_on_i,
  output logic osc_clk_o,
  output logic ext_clk_o
);
  // ----------------------------------------
  // sources
  // ----------------------------------------
  // the resonator only swings while the cell drives it; it rests low
  always
  begin
    if (osc_run_i === 1'b1)
    begin
      #XTAL_HALF_NS;
      osc_clk_o = ~osc_clk_o;
    end
    else
    begin
      osc_clk_o = 1'b0;
      @(osc_run_i);
      // start off the sampling edge so the pin never races clk_i
      #7;
    end
  end

  // an attached external source runs free, whatever the enable bits say
  always
  begin
    if (ext_on_i === 1'b1)
    begin
      #EXT_HALF_NS;
      ext_clk_o = ~ext_clk_o;
    end
    else
    begin
      ext_clk_o = 1'b0;
      @(ext_on_i);
      #7;
    end
  end
endmodule

// *** tb/high_speed_clock_control_tb.sv ***
// self-checking bench for the high-speed clock control block
`timescale 1ns/10ps
module high_speed_clock_control_tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic sub = 1'b0;
  logic stp = 1'b0;
  logic wk = 1'b0;
  logic ext_on = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, osc_clk, ext_clk, osc_run_o, osc_gain_o, ext_input_en_o;
  logic crystal_in_pin_port_o, crystal_out_pin_port_o, crystal_out_pin_ext_o;
  logic main_clk_en_o, periph_clk_en_o, cpu_clk_en_o, standby_o;
  logic [31:0] rd;
  int failures = 0;
  int checks = 0;
  int n;
  int i;
  int sub_cnt = 0;
  int ext_edges = 0;

  hsc_top hsc_top_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_clk_i(osc_clk),
    .ext_clk_pin_i(ext_clk), .subsys_tick_i(sub), .stop_insn_i(stp),
    .wake_i(wk), .osc_run_o(osc_run_o), .osc_gain_o(osc_gain_o),
    .ext_input_en_o(ext_input_en_o),
    .crystal_in_pin_port_o(crystal_in_pin_port_o),
    .crystal_out_pin_port_o(crystal_out_pin_port_o),
    .crystal_out_pin_ext_o(crystal_out_pin_ext_o),
    .main_clk_en_o(main_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .cpu_clk_en_o(cpu_clk_en_o), .standby_o(standby_o)
  );

  hsc_clk_src hsc_clk_src_inst (
    .osc_run_i(osc_run_o),
    .ext_on_i(ext_on),
    .osc_clk_o(osc_clk),
    .ext_clk_o(ext_clk)
  );

  // ----------------------------------------
  // clock, subsystem ticks, edge counter
  // ----------------------------------------
  always #25 clk_i = ~clk_i;

  // subsystem clock enable: one cycle in four
  always @(posedge clk_i)
  begin
    sub_cnt <= sub_cnt + 1;
    sub <= (sub_cnt % 4 == 3);
  end

  always @(posedge ext_clk) ext_edges++;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; read data is taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    // a missing ack is left to the watchdog
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // which: 0 cpu, 1 main, 2 peripheral enable
  task automatic count_en(input int which, input int len, output int cnt);
    logic [2:0] v;
    cnt = 0;
    repeat (len)
    begin
      @(posedge clk_i);
      v = {periph_clk_en_o, main_clk_en_o, cpu_clk_en_o};
      if (v[which] === 1'b1)
        cnt++;
    end
  endtask

  task automatic wait_cpu(output int cnt);
    cnt = 0;
    @(posedge clk_i);
    while (cpu_clk_en_o !== 1'b1 && cnt < 2000)
    begin
      @(posedge clk_i);
      cnt++;
    end
  endtask

  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic complete_run();
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #1_000_000;
    failures++;
    complete_run();
  end

  initial
  begin
    do_reset();
    check(crystal_in_pin_port_o, 1);
    check(crystal_out_pin_port_o, 1);
    wb(0, 8'h04, 0);
    check(rd, 32'h80);
    wb(0, 8'h0c, 0);
    check(rd, 32'h01);
    wb(0, 8'h08, 0);
    check(rd, 32'h00);
    wb(0, 8'h20, 0);
    check(rd, 32'h00);
    count_en(1, 64, n);
    check(n, 64);
    // code 5 is prohibited: the last legal ratio must stay
    for (i = 0; i < 6; i++)
    begin
      wb(1, 8'h0c, i);
      repeat (40) @(posedge clk_i);
      count_en(0, 64, n);
      check(n, 64 >> ((i == 5) ? 4 : i));
    end
    wb(1, 8'h0c, 32'h10);
    repeat (40) @(posedge clk_i);
    wb(0, 8'h0c, 0);
    check(rd, 32'h30);
    count_en(0, 64, n);
    check(n, 16);
    wb(1, 8'h0c, 32'h00);
    repeat (40) @(posedge clk_i);
    wb(1, 8'h00, 32'h40);
    repeat (2) @(posedge clk_i);
    check(crystal_in_pin_port_o, 0);
    check(crystal_out_pin_port_o, 0);
    check(crystal_out_pin_ext_o, 0);
    wb(1, 8'h04, 0);
    repeat (2) @(posedge clk_i);
    check(osc_run_o, 1);
    count_en(0, 64, n);
    check(n, 64);
    wb(0, 8'h10, 0);
    check(rd != 0, 1);
    wb(1, 8'h00, 32'h41);
    wait_cpu(n);
    check(n >= 80 && n <= 330, 1);
    check(osc_gain_o, 1);
    wb(1, 8'h00, 32'h40);
    wb(0, 8'h00, 0);
    check(rd, 32'h41);
    wb(1, 8'h08, 32'h05);
    repeat (40) @(posedge clk_i);
    wb(0, 8'h08, 0);
    check(rd, 32'h07);
    count_en(1, 200, n);
    check(n >= 48 && n <= 52, 1);
    count_en(2, 200, n);
    check(n >= 48 && n <= 52, 1);
    // standby on the crystal: wake waits 2^8 edges of four cycles each
    wb(1, 8'h14, 32'h00);
    stp <= 1'b1;
    @(posedge clk_i);
    stp <= 1'b0;
    wk <= 1'b1;
    @(posedge clk_i);
    wk <= 1'b0;
    wait_cpu(n);
    check(n >= 1016 && n <= 1060, 1);
    wb(1, 8'h08, 32'h00);
    repeat (40) @(posedge clk_i);
    wb(0, 8'h08, 0);
    check(rd, 32'h00);
    wb(1, 8'h04, 32'h80);
    repeat (2) @(posedge clk_i);
    check(osc_run_o, 0);
    // second life: external clock on the second pin
    ext_on <= 1'b1;
    do_reset();
    check(osc_gain_o, 0);
    wb(1, 8'h00, 32'hc0);
    repeat (2) @(posedge clk_i);
    check(crystal_in_pin_port_o, 1);
    check(crystal_out_pin_ext_o, 1);
    wb(1, 8'h04, 0);
    repeat (2) @(posedge clk_i);
    check(ext_input_en_o, 1);
    check(osc_run_o, 0);
    wb(1, 8'h00, 32'hc1);
    ext_edges = 0;
    wait_cpu(n);
    check(ext_edges >= 158 && ext_edges <= 162, 1);
    wb(1, 8'h14, 32'h00);
    stp <= 1'b1;
    @(posedge clk_i);
    stp <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(standby_o, 1);
    check(ext_input_en_o, 0);
    wk <= 1'b1;
    @(posedge clk_i);
    wk <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(standby_o, 0);
    complete_run();
  end
endmodule
